// ===== design/dma_event_pkg.sv
/*
  Shared constants and carriers for the Ethernet DMA event status bank:
  register offsets, flag bit positions, control field layout and frame
  length limits. Assumes a 32-bit APB register bus.
*/
package dma_event_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h00;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h04;
  localparam logic [7:0] OFS_DMA_OP_CTRL = 8'h08;
  localparam logic [7:0] OFS_DMA_RUN_STATE = 8'h0C;

  // ----------------------------------------------------------------
  // flag bit positions in event_status_reg / event_enable_reg
  // ----------------------------------------------------------------
  localparam int BIT_TX_UNDERRUN = 19;
  localparam int BIT_RX_DONE = 18;
  localparam int BIT_RX_DESC_EMPTY = 17;
  localparam int BIT_RX_OVERFLOW = 16;
  localparam int BIT_TX_LEN_ILLEGAL = 12;
  localparam int BIT_NO_CARRIER = 11;
  localparam int BIT_CARRIER_LOST = 10;
  localparam int BIT_COLLISION = 9;
  localparam int BIT_RETRY_EXCEEDED = 8;
  localparam int BIT_RX_MULTICAST = 7;
  localparam int BIT_RX_DISCARD_REQ = 5;
  localparam int BIT_RX_PARTIAL_BIT = 4;
  localparam int BIT_RX_OVERSIZE = 3;
  localparam int BIT_RX_UNDERSIZE = 2;

  // implemented flag bits; everything else reads as zero
  localparam logic [31:0] FLAG_MASK = 32'h000F1FBC;
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // dma_op_control_reg fields
  // ----------------------------------------------------------------
  localparam int CTL_HALT_ON_UNDERRUN = 0;
  localparam int CTL_HALT_ON_OVERFLOW = 1;
  localparam int CTL_TX_RESTART = 2;
  localparam int CTL_RX_RESTART = 3;
  localparam logic [1:0] CTL_RESET = 2'h0;

  // dma_run_state fields
  localparam int RUN_TX = 0;
  localparam int RUN_RX = 1;

  // ----------------------------------------------------------------
  // frame limits
  // ----------------------------------------------------------------
  localparam int TX_LEN_MIN = 4;
  localparam int RX_LEN_LONG = 1519;
  localparam int RX_LEN_SHORT = 64;
  localparam int TX_ATTEMPTS = 16;

  // event pulses from the mac core and dma datapath
  typedef struct packed {
    logic tx_fifo_underflow;
    logic tx_start;
    logic tx_attempt_fail;
    logic tx_collision;
    logic rx_desc_updated;
    logic rx_desc_fetch;
    logic rx_desc_owner_bit;
    logic rx_fifo_overflow;
    logic rx_frame_end;
    logic rx_multicast;
    logic rx_residual_bits;
    logic rx_discard_req;
    logic rx_discard_possible;
  } mac_events_t;

endpackage

// ===== design/dma_event_status.sv
/*
  Event status bank of an Ethernet DMA controller: sticky event flags,
  their enables and the interrupt request, plus the halt/continue control
  of the transmit and receive DMA. Assumes event pulses and levels arrive
  synchronous to pclk and that software reaches the registers over APB.
*/
`timescale 1ns/1ps

module dma_event_status #(
  parameter int LEN_W = 16
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events from mac core and dma datapath
  input wire dma_event_pkg::mac_events_t events,
  input wire logic tx_active,
  input wire logic carrier_sense,
  input wire logic [LEN_W-1:0] tx_len,
  input wire logic [LEN_W-1:0] rx_len,
  // dma control and interrupt
  output logic tx_dma_run,
  output logic rx_dma_run,
  output logic rx_overflow_writeback,
  output logic irq
);

  if (LEN_W < 11 || LEN_W > 32) begin : g_len_check
    $error("LEN_W must hold a length of 1519");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic wr_access;
  logic hit_status;
  logic hit_enable;
  logic hit_ctrl;
  logic hit_run;
  logic mapped;
  logic [31:0] wmask;

  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign hit_status = (paddr == dma_event_pkg::OFS_EVENT_STATUS);
  assign hit_enable = (paddr == dma_event_pkg::OFS_EVENT_ENABLE);
  assign hit_ctrl = (paddr == dma_event_pkg::OFS_DMA_OP_CTRL);
  assign hit_run = (paddr == dma_event_pkg::OFS_DMA_RUN_STATE);
  assign mapped = hit_status | hit_enable | hit_ctrl | hit_run;
  // zero wait states: every access completes in its first access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic carrier_prev_reg;
  logic [4:0] attempt_cnt_reg;
  logic [31:0] set_vec;
  logic retry_over;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_prev_reg <= 1'b0;
    end else begin
      carrier_prev_reg <= carrier_sense;
    end
  end

  // failed attempts per frame; a new frame restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attempt_cnt_reg <= 5'h00;
    end else if (events.tx_start) begin
      attempt_cnt_reg <= 5'h00;
    end else if (events.tx_attempt_fail && !retry_over) begin
      attempt_cnt_reg <= attempt_cnt_reg + 5'h01;
    end
  end

  // the last of the sixteen attempts fails
  assign retry_over = events.tx_attempt_fail &&
    (attempt_cnt_reg == 5'(dma_event_pkg::TX_ATTEMPTS - 1));

  always_comb begin
    set_vec = 32'h00000000;
    set_vec[dma_event_pkg::BIT_TX_UNDERRUN] =
      events.tx_fifo_underflow & tx_active;
    set_vec[dma_event_pkg::BIT_RX_DONE] = events.rx_desc_updated;
    set_vec[dma_event_pkg::BIT_RX_DESC_EMPTY] =
      events.rx_desc_fetch & ~events.rx_desc_owner_bit;
    set_vec[dma_event_pkg::BIT_RX_OVERFLOW] = events.rx_fifo_overflow;
    set_vec[dma_event_pkg::BIT_TX_LEN_ILLEGAL] = events.tx_start &&
      (tx_len < LEN_W'(dma_event_pkg::TX_LEN_MIN));
    set_vec[dma_event_pkg::BIT_NO_CARRIER] =
      events.tx_start & ~carrier_sense;
    set_vec[dma_event_pkg::BIT_CARRIER_LOST] =
      tx_active & carrier_prev_reg & ~carrier_sense;
    set_vec[dma_event_pkg::BIT_COLLISION] =
      events.tx_collision & tx_active;
    set_vec[dma_event_pkg::BIT_RETRY_EXCEEDED] = retry_over;
    set_vec[dma_event_pkg::BIT_RX_MULTICAST] =
      events.rx_frame_end & events.rx_multicast;
    set_vec[dma_event_pkg::BIT_RX_DISCARD_REQ] =
      events.rx_discard_req & ~events.rx_discard_possible;
    set_vec[dma_event_pkg::BIT_RX_PARTIAL_BIT] =
      events.rx_frame_end & events.rx_residual_bits;
    set_vec[dma_event_pkg::BIT_RX_OVERSIZE] = events.rx_frame_end &&
      (rx_len >= LEN_W'(dma_event_pkg::RX_LEN_LONG));
    set_vec[dma_event_pkg::BIT_RX_UNDERSIZE] = events.rx_frame_end &&
      (rx_len < LEN_W'(dma_event_pkg::RX_LEN_SHORT));
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  logic [31:0] event_status_reg;
  logic [31:0] clr_vec;

  assign clr_vec = (wr_access && hit_status) ? (pwdata & wmask) : 32'h00000000;

  // unimplemented and reserved positions never hold a flop
  for (genvar b = 0; b < 32; b++) begin : g_flag
    if (dma_event_pkg::FLAG_MASK[b]) begin : g_impl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          event_status_reg[b] <= dma_event_pkg::FLAG_RESET[b];
        end else if (set_vec[b]) begin
          event_status_reg[b] <= 1'b1;
        end else if (clr_vec[b]) begin
          event_status_reg[b] <= 1'b0;
        end
      end
    end else begin : g_zero
      assign event_status_reg[b] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enables and interrupt
  // ----------------------------------------------------------------
  logic [31:0] event_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_enable_reg <= dma_event_pkg::ENABLE_RESET;
    end else if (wr_access && hit_enable) begin
      event_enable_reg <= ((event_enable_reg & ~wmask) | (pwdata & wmask)) &
        dma_event_pkg::FLAG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status_reg & event_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // dma operation control
  // ----------------------------------------------------------------
  logic [1:0] dma_op_control_reg;
  logic tx_restart;
  logic rx_restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_op_control_reg <= dma_event_pkg::CTL_RESET;
    end else if (wr_access && hit_ctrl && pstrb[0]) begin
      dma_op_control_reg <= pwdata[1:0];
    end
  end

  // restart bits act on write and are not stored
  assign tx_restart = wr_access && hit_ctrl && pstrb[0] &&
    pwdata[dma_event_pkg::CTL_TX_RESTART];
  assign rx_restart = wr_access && hit_ctrl && pstrb[0] &&
    pwdata[dma_event_pkg::CTL_RX_RESTART];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dma_run <= 1'b1;
    end else if (set_vec[dma_event_pkg::BIT_TX_UNDERRUN] &&
                 dma_op_control_reg[dma_event_pkg::CTL_HALT_ON_UNDERRUN]) begin
      tx_dma_run <= 1'b0;
    end else if (tx_restart) begin
      tx_dma_run <= 1'b1;
    end
  end

  // reception stops on an inactive descriptor until software re-arms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dma_run <= 1'b1;
    end else if (set_vec[dma_event_pkg::BIT_RX_DESC_EMPTY] ||
                 (set_vec[dma_event_pkg::BIT_RX_OVERFLOW] &&
                  dma_op_control_reg[dma_event_pkg::CTL_HALT_ON_OVERFLOW])) begin
      rx_dma_run <= 1'b0;
    end else if (rx_restart) begin
      rx_dma_run <= 1'b1;
    end
  end

  // status of the overflowing frame still goes to its descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overflow_writeback <= 1'b0;
    end else begin
      rx_overflow_writeback <= events.rx_fifo_overflow;
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      unique case (1'b1)
        hit_status: prdata <= event_status_reg;
        hit_enable: prdata <= event_enable_reg;
        hit_ctrl: prdata <= {30'h00000000, dma_op_control_reg};
        hit_run: prdata <= {30'h00000000, rx_dma_run, tx_dma_run};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_underrun_sets: assert property (@(posedge pclk) disable iff (!presetn)
    events.tx_fifo_underflow && tx_active |=> event_status_reg[19])
    else $error("underrun did not set flag");

  a_underrun_halt: assert property (@(posedge pclk) disable iff (!presetn)
    events.tx_fifo_underflow && tx_active && dma_op_control_reg[0] |=> !tx_dma_run)
    else $error("tx dma not halted");

  a_desc_empty_stop: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_desc_fetch && !events.rx_desc_owner_bit |=> event_status_reg[17] && !rx_dma_run)
    else $error("empty descriptor not flagged");

  a_writeback_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(events.rx_fifo_overflow) |=> $rose(rx_overflow_writeback))
    else $error("overflow writeback missing");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    event_status_reg[15:13] == 3'h0 && event_status_reg[6] == 1'b0)
    else $error("reserved status bits set");

  a_short_tx_len: assert property (@(posedge pclk) disable iff (!presetn)
    events.tx_start && tx_len == LEN_W'(3) |=> event_status_reg[12])
    else $error("short transmit length not flagged");

  a_oversize_edge: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_frame_end && rx_len == LEN_W'(1519) |=> event_status_reg[3])
    else $error("oversize frame not flagged");

  a_undersize_edge: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_frame_end && rx_len == LEN_W'(64) && !event_status_reg[2] ##1
    !set_vec[2] |-> !event_status_reg[2])
    else $error("64-byte frame flagged as short");

  a_clear_on_one: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && hit_status && pstrb[1] && pwdata[9] && !set_vec[9] |=> !event_status_reg[9])
    else $error("write one did not clear");

  a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    set_vec[18] && clr_vec[18] |=> event_status_reg[18])
    else $error("set lost against clear");

  a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    event_status_reg[16] && !clr_vec[16] |=> event_status_reg[16])
    else $error("flag dropped without clear");

  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (event_enable_reg == 32'h00000000) [*2] |-> !irq)
    else $error("interrupt with all enables off");

  a_retry_count: assert property (@(posedge pclk) disable iff (!presetn)
    set_vec[8] |-> attempt_cnt_reg == 5'h0F)
    else $error("retry over at wrong attempt");

  a_frame_done: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_desc_updated |=> event_status_reg[18])
    else $error("received frame not flagged");

  a_overflow_sets: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_fifo_overflow |=> event_status_reg[16])
    else $error("receive overflow not flagged");

  a_no_carrier: assert property (@(posedge pclk) disable iff (!presetn)
    events.tx_start && !carrier_sense |=> event_status_reg[11])
    else $error("missing carrier not flagged");

  a_carrier_lost: assert property (@(posedge pclk) disable iff (!presetn)
    tx_active && carrier_prev_reg && !carrier_sense |=> event_status_reg[10])
    else $error("carrier loss not flagged");

  a_multicast_sets: assert property (@(posedge pclk) disable iff (!presetn)
    events.rx_frame_end && events.rx_multicast |=> event_status_reg[7])
    else $error("multicast frame not flagged");

endmodule

// ===== dv/mac_event_source.sv
/*
  Behavioural mac core and dma datapath: raises one kind of event per
  request. Assumes the bench pulses fire for one pclk cycle with kind/len.
*/
`timescale 1ns/1ps

module mac_event_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request
  input wire logic fire,
  input wire logic [3:0] kind,
  input wire logic [15:0] len,
  output logic busy,
  // toward the status bank
  output dma_event_pkg::mac_events_t events,
  output logic tx_active,
  output logic carrier_sense,
  output logic [15:0] tx_len,
  output logic [15:0] rx_len
);
  logic [4:0] step_reg;
  logic on_line;

  assign busy = (step_reg != 5'h00);
  assign on_line = (kind == 4'h0) || (kind == 4'h6) || (kind == 4'h7);

  // lengths are scrambled outside their strobe so a stale value never helps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 5'h00;
      events <= '0;
      tx_active <= 1'b0;
      carrier_sense <= 1'b1;
      tx_len <= 16'h5A5A;
      rx_len <= 16'hA5A5;
    end else begin
      events <= '0;
      tx_len <= ~tx_len;
      rx_len <= ~rx_len;
      carrier_sense <= 1'b1;
      tx_active <= 1'b0;
      if (fire) begin
        step_reg <= 5'h01;
        tx_active <= on_line;
        events.tx_start <= (kind == 4'h8);
        tx_len <= 16'h0040;
      end else if (busy) begin
        // attempts keep coming until len of them have failed
        if (kind == 4'h8 && step_reg < len[4:0]) begin
          step_reg <= step_reg + 5'h01;
        end else begin
          step_reg <= 5'h00;
        end
        tx_active <= on_line;
        case (kind)
          4'h0: events.tx_fifo_underflow <= 1'b1;
          4'h1: events.rx_desc_updated <= 1'b1;
          4'h2: begin
            events.rx_desc_fetch <= 1'b1;
            events.rx_desc_owner_bit <= len[0];
          end
          4'h3: events.rx_fifo_overflow <= 1'b1;
          4'h4: begin
            events.tx_start <= 1'b1;
            tx_len <= len;
          end
          4'h5: begin
            events.tx_start <= 1'b1;
            carrier_sense <= 1'b0;
            tx_len <= 16'h0040;
          end
          4'h6: carrier_sense <= 1'b0;
          4'h7: events.tx_collision <= 1'b1;
          4'h8: events.tx_attempt_fail <= 1'b1;
          4'h9: begin
            events.rx_frame_end <= 1'b1;
            events.rx_multicast <= 1'b1;
            rx_len <= 16'h0064;
          end
          4'hA: begin
            events.rx_discard_req <= 1'b1;
            events.rx_discard_possible <= len[0];
          end
          4'hB: begin
            events.rx_frame_end <= 1'b1;
            events.rx_residual_bits <= 1'b1;
            rx_len <= 16'h0064;
          end
          default: begin
            events.rx_frame_end <= 1'b1;
            rx_len <= len;
          end
        endcase
      end
    end
  end
endmodule

// ===== dv/testbench.sv
/*
  Self-checking bench of the event status bank over APB.
  Assumes mac_event_source as the far side; reads are checked from a queue.
*/
`timescale 1ns/1ps

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cfg, rnd;
  logic [3:0] pstrb, kind;
  logic tx_dma_run, rx_dma_run, rx_overflow_writeback;
  logic tx_active, carrier_sense, fire, busy;
  logic [15:0] tx_len, rx_len, len, l;
  dma_event_pkg::mac_events_t events;
  logic [32:0] q[$];
  int n_errors, n_checks, n_wb, j;

  dma_event_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .tx_active(tx_active),
    .carrier_sense(carrier_sense), .tx_len(tx_len), .rx_len(rx_len),
    .tx_dma_run(tx_dma_run), .rx_dma_run(rx_dma_run),
    .rx_overflow_writeback(rx_overflow_writeback), .irq(irq));

  mac_event_source mac (.pclk(pclk), .presetn(presetn), .fire(fire), .kind(kind),
    .len(len), .busy(busy), .events(events), .tx_active(tx_active),
    .carrier_sense(carrier_sense), .tx_len(tx_len), .rx_len(rx_len));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (rx_overflow_writeback === 1'b1) n_wb++;
    if (psel && penable && pready && !pwrite) begin
      n_checks++;
      if (q.size() == 0 || {pslverr, prdata} !== q[0]) begin
        n_errors++;
        $display("mismatch at %0t read %h got %h", $time, paddr, prdata);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t apb transfer timed out", $time);
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask

  // one event, then flag, irq and run state, then write-0 and write-1
  task automatic ev(input logic [3:0] k, input logic [15:0] n, input logic [31:0] m,
                    input logic [1:0] r);
    int i;
    kind <= k;
    len <= n;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    for (i = 0; i < 40 && busy; i++) @(posedge pclk);
    if (busy) begin
      n_errors++;
      $display("mismatch at %0t event source stuck busy", $time);
      stop_test();
    end
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, |m});
    rd(dma_event_pkg::OFS_EVENT_STATUS, m);
    rd(dma_event_pkg::OFS_DMA_RUN_STATE, {30'h0, r});
    apb(1'b1, dma_event_pkg::OFS_EVENT_STATUS, 32'h0);
    rd(dma_event_pkg::OFS_EVENT_STATUS, m);
    apb(1'b1, dma_event_pkg::OFS_EVENT_STATUS, m);
    rd(dma_event_pkg::OFS_EVENT_STATUS, 32'h0);
    apb(1'b1, dma_event_pkg::OFS_DMA_OP_CTRL, cfg | 32'h0000000C);
    $display("event kind %0d len %0d done", k, n);
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    $display("mismatch at %0t run timed out", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    fire = 1'b0;
    kind = 4'h0;
    len = 16'h0;
    cfg = 32'h0;
    rnd = 32'h7E26;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(dma_event_pkg::OFS_EVENT_STATUS, 32'h0);
    rd(dma_event_pkg::OFS_EVENT_ENABLE, 32'h0);
    rd(dma_event_pkg::OFS_DMA_OP_CTRL, 32'h0);
    rd(dma_event_pkg::OFS_DMA_RUN_STATE, 32'h3);
    q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h10, 32'h0);
    pstrb <= 4'h1;
    apb(1'b1, dma_event_pkg::OFS_EVENT_ENABLE, 32'hFFFFFFFF);
    pstrb <= 4'hF;
    rd(dma_event_pkg::OFS_EVENT_ENABLE, dma_event_pkg::FLAG_MASK & 32'h000000FF);
    apb(1'b1, dma_event_pkg::OFS_EVENT_ENABLE, 32'hFFFFFFFF);
    rd(dma_event_pkg::OFS_EVENT_ENABLE, dma_event_pkg::FLAG_MASK);
    apb(1'b1, dma_event_pkg::OFS_DMA_RUN_STATE, 32'h0);
    rd(dma_event_pkg::OFS_DMA_RUN_STATE, 32'h3);
    $display("reset and map test done");
    ev(4'h0, 16'd0, 32'h00080000, 2'h3);
    ev(4'h1, 16'd0, 32'h00040000, 2'h3);
    ev(4'h2, 16'd1, 32'h00000000, 2'h3);
    ev(4'h2, 16'd0, 32'h00020000, 2'h1);
    ev(4'h3, 16'd0, 32'h00010000, 2'h3);
    ev(4'h4, 16'd3, 32'h00001000, 2'h3);
    ev(4'h4, 16'd4, 32'h00000000, 2'h3);
    ev(4'h5, 16'd0, 32'h00000800, 2'h3);
    ev(4'h6, 16'd0, 32'h00000400, 2'h3);
    ev(4'h7, 16'd0, 32'h00000200, 2'h3);
    ev(4'h8, 16'd15, 32'h00000000, 2'h3);
    ev(4'h8, 16'd16, 32'h00000100, 2'h3);
    ev(4'h9, 16'd0, 32'h00000080, 2'h3);
    ev(4'hA, 16'd0, 32'h00000020, 2'h3);
    ev(4'hA, 16'd1, 32'h00000000, 2'h3);
    ev(4'hB, 16'd0, 32'h00000010, 2'h3);
    ev(4'hC, 16'd1519, 32'h00000008, 2'h3);
    ev(4'hC, 16'd1518, 32'h00000000, 2'h3);
    ev(4'hC, 16'd63, 32'h00000004, 2'h3);
    ev(4'hC, 16'd64, 32'h00000000, 2'h3);
    cfg = 32'h3;
    apb(1'b1, dma_event_pkg::OFS_DMA_OP_CTRL, cfg);
    rd(dma_event_pkg::OFS_DMA_OP_CTRL, 32'h3);
    ev(4'h0, 16'd0, 32'h00080000, 2'h2);
    ev(4'h3, 16'd0, 32'h00010000, 2'h1);
    chk(n_wb, 32'd2);
    for (j = 0; j < 8; j++) begin
      rnd = lfsr_next(rnd);
      l = {4'h0, rnd[11:0]};
      ev(4'hC, l, ((l >= 16'(dma_event_pkg::RX_LEN_LONG)) ? 32'h8 : 32'h0) |
         ((l < 16'(dma_event_pkg::RX_LEN_SHORT)) ? 32'h4 : 32'h0), 2'h3);
    end
    // the clear lands on the very edge that sets the flag, then reset mid-run
    kind <= 4'h1;
    fire <= 1'b1;
    fork
      apb(1'b1, dma_event_pkg::OFS_EVENT_STATUS, 32'h00040000);
      begin
        @(posedge pclk);
        fire <= 1'b0;
      end
    join
    rd(dma_event_pkg::OFS_EVENT_STATUS, 32'h00040000);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rd(dma_event_pkg::OFS_EVENT_STATUS, 32'h0);
    rd(dma_event_pkg::OFS_EVENT_ENABLE, 32'h0);
    rd(dma_event_pkg::OFS_DMA_OP_CTRL, 32'h0);
    rd(dma_event_pkg::OFS_DMA_RUN_STATE, 32'h3);
    $display("set against clear and mid-run reset test done");
    stop_test();
  end
endmodule
